// [ast_seq_timing.sv]
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Post filter 4 period 4736, first equals period
// - Decimation is unsigned 11-bit field value
// - Post-processing delay 28/62/69 by filter, decimation
// - Switch channel at conversion end, ready after delay
// - New settling overlaps previous post-processing delay
// - Shared setup gives fixed settle-plus-ideal interval
// - Per-channel rate is sequence rate over channels
// - Filter shape follows only mode and decimation
// - Sinc4 first 4x32xdec, later every 32xdec
// - Sinc3 and notch first 3x32xdec, later 32xdec
// - Sinc4 averaging period (4+8-1)x32xdec
// - Sinc3 averaging period (3+8-1)x32xdec
// - Post filters use fixed 2944/3200/3968/4736 periods
// - Duty standby derived from conversion times, ratio
// - Active time sums settle plus ideal first
// - Duty wake overlaps first channel settling
// - Standby is ratio times ideal sum minus wake
// - Standby indicator output low during standby
// - Oscillator off in host standby, settle before acquisition
// - Duty cycling keeps oscillator alive by default
// - Settle code selects 32 to 4096 cycles
// - Cycle through enabled channels, honour repeats
module ast_seq_timing
	import ast_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	output logic data_ready_n, // Low once a result is ready
	output logic [2:0] result_channel, // Channel of latest result
	output logic conv_active, // High while a conversion runs
	output logic [2:0] active_channel, // Channel being converted
	output logic [3:0] filter_mode_out, // Filter mode to filter
	output logic [10:0] decimation_out, // Decimation to filter
	output logic standby_indicator_output, // Low in standby
	output logic osc_enable // Internal oscillator enable
);

	////////////////////////////////////////////////////////////////
	// Registers and per-channel timing

	logic [4:0] ctrl_reg;
	logic [7:0] chan_en_reg;
	logic [21:0] setup_reg [NCH];
	logic [TW-1:0] settle_cyc [NCH];
	logic [TW-1:0] cnv_cyc [NCH];
	logic [TW-1:0] first_cyc [NCH];
	logic [TW-1:0] dpp_cyc [NCH];
	logic [TW-1:0] active_reg;
	logic [TW-1:0] standby_reg;
	logic [TW-1:0] active_sum;
	logic [TW-1:0] ideal_sum;
	logic [TW-1:0] ratio_prod;

	// Settled conversion period
	function automatic logic [TW-1:0] cnv_of(input logic [3:0] m,
			input logic [10:0] d);
		logic [TW-1:0] dw;
		dw = TW'(d);
		case (m)
			FM_SINC4, FM_SINC3, FM_SINC3_NOTCH: cnv_of = dw << 5;
			FM_SINC4_AVG: cnv_of = TW'(dw * AVG4_MUL);
			FM_SINC3_AVG: cnv_of = TW'(dw * AVG3_MUL);
			FM_POST1: cnv_of = POST1_CYC;
			FM_POST2: cnv_of = POST2_CYC;
			FM_POST3: cnv_of = POST3_CYC;
			FM_POST4: cnv_of = POST4_CYC;
			default: cnv_of = dw << 5;
		endcase
	endfunction : cnv_of

	// Ideal first conversion on a new channel
	function automatic logic [TW-1:0] first_of(input logic [3:0] m,
			input logic [TW-1:0] c);
		case (m)
			FM_SINC4: first_of = c << 2;
			FM_SINC3, FM_SINC3_NOTCH: first_of = TW'((c << 1) + c);
			default: first_of = c;
		endcase
	endfunction : first_of

	// Post-processing delay
	function automatic logic [TW-1:0] dpp_of(input logic [3:0] m,
			input logic [10:0] d);
		case (m)
			FM_SINC4, FM_SINC3, FM_SINC3_NOTCH:
				dpp_of = (d <= 11'h001) ? DPP_SHORT : DPP_LONG;
			FM_POST1, FM_POST2, FM_POST3, FM_POST4: dpp_of = DPP_POST;
			default: dpp_of = DPP_LONG;
		endcase
	endfunction : dpp_of

	for (genvar g = 0; g < NCH; g++) begin : g_chan
		logic [3:0] mode_g;
		logic [10:0] dec_g;
		assign mode_g = setup_reg[g][SU_MODE_LSB +: 4];
		assign dec_g = setup_reg[g][SU_DEC_LSB +: 11];
		// Settle code is a shift of the 32-cycle floor
		assign settle_cyc[g] = SETTLE_BASE << setup_reg[g][SU_SET_LSB +: 3];
		assign cnv_cyc[g] = cnv_of(mode_g, dec_g);
		assign first_cyc[g] = first_of(mode_g, cnv_cyc[g]);
		assign dpp_cyc[g] = dpp_of(mode_g, dec_g);
	end

	// Duty-cycling sums over enabled channels; no post-processing term
	always_comb begin
		active_sum = '0;
		ideal_sum = '0;
		for (int i = 0; i < NCH; i++) begin
			if (chan_en_reg[i]) begin
				active_sum = TW'(active_sum + settle_cyc[i] + first_cyc[i]);
				ideal_sum = TW'(ideal_sum + first_cyc[i]);
			end
		end
		ratio_prod = TW'(ideal_sum * (ctrl_reg[CTRL_RATIO] ?
			RATIO_SIXTEENTH : RATIO_QUARTER));
	end

	// Registered so the long adder chain stays off the sequencer path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_reg <= '0;
			standby_reg <= '0;
		end else begin
			active_reg <= active_sum;
			// Clamped: a wake longer than the budget leaves no standby
			standby_reg <= (ratio_prod > DUTY_WAKE_CYC) ?
				TW'(ratio_prod - DUTY_WAKE_CYC) : '0;
		end
	end

	////////////////////////////////////////////////////////////////
	// APB slave

	logic setup_ph;
	logic [2:0] su_idx;
	logic su_hit;
	logic [31:0] rd_mux;
	logic rd_ok;
	logic [2:0] cur_ch_reg;
	ast_state_type state_reg;

	assign setup_ph = psel && !penable;
	assign su_idx = paddr[4:2];
	assign su_hit = (paddr >= OFS_SETUP0) && (paddr <= OFS_SETUP7) &&
		(paddr[1:0] == 2'b00);

	// Read decode
	always_comb begin
		rd_mux = '0;
		rd_ok = 1'b1;
		if (su_hit) begin
			rd_mux = {10'h000, setup_reg[su_idx]};
		end else begin
			unique case (paddr)
				OFS_CTRL: rd_mux = {27'h0000000, ctrl_reg};
				OFS_CHAN_EN: rd_mux = {24'h000000, chan_en_reg};
				OFS_STATUS: rd_mux = {22'h000000, osc_enable,
					!standby_indicator_output, result_channel,
					cur_ch_reg, data_ready_n, conv_active};
				OFS_ACTIVE: rd_mux = {4'h0, active_reg};
				OFS_STANDBY: rd_mux = {4'h0, standby_reg};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// Answer is prepared in setup so the access phase ends at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph && !rd_ok;
			prdata <= (setup_ph && !pwrite && rd_ok) ? rd_mux : '0;
		end
	end

	// Register writes take effect at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RESET;
			chan_en_reg <= CHAN_EN_RESET;
			for (int i = 0; i < NCH; i++) begin
				setup_reg[i] <= SETUP_RESET;
			end
		end else if (psel && penable && pready && pwrite) begin
			if (su_hit) begin
				setup_reg[su_idx] <= pwdata[21:0];
			end else if (paddr == OFS_CTRL) begin
				ctrl_reg <= pwdata[4:0];
			end else if (paddr == OFS_CHAN_EN) begin
				chan_en_reg <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Main clock enable

	logic [8:0] div_cnt;
	logic mclk_tick;

	// One pulse per main clock period; all intervals count these
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= '0;
			mclk_tick <= 1'b0;
		end else begin
			mclk_tick <= (div_cnt == MCLK_DIV_LAST);
			div_cnt <= (div_cnt == MCLK_DIV_LAST) ? 9'h000 : 9'(div_cnt + 9'h001);
		end
	end

	////////////////////////////////////////////////////////////////
	// Channel walk

	logic [2:0] nxt_ch;
	logic [2:0] first_ch;
	logic wrap;

	// Next enabled channel after the current one, and the lowest enabled
	always_comb begin
		logic found;
		found = 1'b0;
		nxt_ch = cur_ch_reg;
		first_ch = '0;
		for (int i = 1; i <= NCH; i++) begin
			if (!found && chan_en_reg[3'(cur_ch_reg + 3'(i))]) begin
				nxt_ch = 3'(cur_ch_reg + 3'(i));
				found = 1'b1;
			end
		end
		for (int i = NCH - 1; i >= 0; i--) begin
			if (chan_en_reg[i]) begin
				first_ch = 3'(i);
			end
		end
		wrap = (nxt_ch <= cur_ch_reg);
	end

	////////////////////////////////////////////////////////////////
	// Sequencer

	logic [TW-1:0] tmr;
	logic [TW-1:0] wake_cnt;
	logic [3:0] rep_cnt;
	logic man_stby;
	logic conv_done;
	logic [2:0] done_ch;
	logic tmr_end;
	logic run_ok;

	// A zero period still lasts one main clock cycle
	assign tmr_end = mclk_tick && (tmr <= 28'h0000001);
	assign run_ok = ctrl_reg[CTRL_RUN] && (chan_en_reg != 8'h00);

	// Every interval is a down-counter reloaded on each phase change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			cur_ch_reg <= '0;
			tmr <= '0;
			wake_cnt <= '0;
			rep_cnt <= '0;
			man_stby <= 1'b0;
			conv_done <= 1'b0;
			done_ch <= '0;
			osc_enable <= 1'b1;
			standby_indicator_output <= 1'b1;
			conv_active <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			if (mclk_tick && tmr > 28'h0000001) begin
				tmr <= TW'(tmr - 28'h0000001);
			end
			if (mclk_tick && wake_cnt != '0) begin
				wake_cnt <= TW'(wake_cnt - 28'h0000001);
			end
			if (!run_ok) begin
				state_reg <= ST_IDLE;
				osc_enable <= 1'b1;
				standby_indicator_output <= 1'b1;
				conv_active <= 1'b0;
			end else if (ctrl_reg[CTRL_STBY] && state_reg != ST_STBY &&
					state_reg != ST_WAKE) begin
				// Host standby: oscillator powered down
				state_reg <= ST_STBY;
				// From idle no channel is chosen yet; pick one that is enabled
				if (state_reg == ST_IDLE) begin
					cur_ch_reg <= first_ch;
				end
				man_stby <= 1'b1;
				osc_enable <= 1'b0;
				standby_indicator_output <= 1'b0;
				conv_active <= 1'b0;
			end else begin
				unique case (state_reg)
					ST_IDLE: begin
						state_reg <= ST_SETTLE;
						cur_ch_reg <= first_ch;
						tmr <= settle_cyc[first_ch];
						wake_cnt <= '0;
					end
					ST_SETTLE: begin
						if (tmr_end && wake_cnt <= 28'h0000001) begin
							state_reg <= ST_CONV;
							conv_active <= 1'b1;
							tmr <= first_cyc[cur_ch_reg];
							rep_cnt <= setup_reg[cur_ch_reg][SU_REP_LSB +: 4];
						end
					end
					ST_CONV: begin
						if (tmr_end) begin
							conv_done <= 1'b1;
							done_ch <= cur_ch_reg;
							if (rep_cnt != 4'h0) begin
								rep_cnt <= 4'(rep_cnt - 4'h1);
								tmr <= cnv_cyc[cur_ch_reg];
							end else begin
								// Switch now; settling overlaps post-processing
								cur_ch_reg <= nxt_ch;
								conv_active <= 1'b0;
								if (ctrl_reg[CTRL_DUTY] && wrap) begin
									state_reg <= ST_STBY;
									man_stby <= 1'b0;
									tmr <= standby_reg;
									osc_enable <= !ctrl_reg[CTRL_OSC_OFF];
									standby_indicator_output <= 1'b0;
								end else begin
									state_reg <= ST_SETTLE;
									tmr <= settle_cyc[nxt_ch];
								end
							end
						end
					end
					ST_STBY: begin
						if (man_stby ? !ctrl_reg[CTRL_STBY] : tmr_end) begin
							standby_indicator_output <= 1'b1;
							if (!osc_enable) begin
								// Oscillator must settle before settling starts
								state_reg <= ST_WAKE;
								osc_enable <= 1'b1;
								tmr <= OSC_WAKE_CYC;
							end else begin
								// Wake runs inside the first settling interval
								state_reg <= ST_SETTLE;
								tmr <= settle_cyc[cur_ch_reg];
								wake_cnt <= DUTY_WAKE_CYC;
							end
						end
					end
					ST_WAKE: begin
						if (tmr_end) begin
							state_reg <= ST_SETTLE;
							tmr <= settle_cyc[cur_ch_reg];
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Post-processing and data ready

	logic [TW-1:0] dpp_tmr;
	logic dpp_busy;
	logic [2:0] dpp_ch;

	// Delay runs on its own so the next channel is never held up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dpp_tmr <= '0;
			dpp_busy <= 1'b0;
			dpp_ch <= '0;
			data_ready_n <= 1'b1;
			result_channel <= '0;
		end else begin
			if (dpp_busy && mclk_tick) begin
				if (dpp_tmr <= 28'h0000001) begin
					dpp_busy <= 1'b0;
					data_ready_n <= 1'b0;
					result_channel <= dpp_ch;
				end else begin
					dpp_tmr <= TW'(dpp_tmr - 28'h0000001);
				end
			end
			if (conv_done) begin
				dpp_busy <= 1'b1;
				dpp_ch <= done_ch;
				dpp_tmr <= dpp_cyc[done_ch];
				data_ready_n <= 1'b1;
			end else if (!run_ok) begin
				dpp_busy <= 1'b0;
				data_ready_n <= 1'b1;
			end
		end
	end

	// Filter shape depends only on the channel's own mode and decimation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_channel <= '0;
			filter_mode_out <= FM_SINC4;
			decimation_out <= '0;
		end else begin
			active_channel <= cur_ch_reg;
			filter_mode_out <= setup_reg[cur_ch_reg][SU_MODE_LSB +: 4];
			decimation_out <= setup_reg[cur_ch_reg][SU_DEC_LSB +: 11];
		end
	end

endmodule : ast_seq_timing

// [ast_pkg.sv]
package ast_pkg;
	// Clocking: pclk 20 MHz, main converter clock nominally 76.8 kHz
	localparam int unsigned PCLK_HZ = 20000000;
	localparam int unsigned MCLK_HZ = 76800;
	localparam int unsigned MCLK_DIV = PCLK_HZ / MCLK_HZ;
	localparam logic [8:0] MCLK_DIV_LAST = 9'(MCLK_DIV - 1);

	// Width of every interval counter, in main clock cycles
	localparam int unsigned TW = 28;
	localparam int unsigned NCH = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHAN_EN = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_ACTIVE = 8'h0c;
	localparam logic [7:0] OFS_STANDBY = 8'h10;
	localparam logic [7:0] OFS_SETUP0 = 8'h20;
	localparam logic [7:0] OFS_SETUP7 = 8'h3c;

	// Control register fields
	localparam int unsigned CTRL_RUN = 0;
	localparam int unsigned CTRL_DUTY = 1;
	localparam int unsigned CTRL_RATIO = 2;
	localparam int unsigned CTRL_STBY = 3;
	localparam int unsigned CTRL_OSC_OFF = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [7:0] CHAN_EN_RESET = 8'h01;

	// Setup register fields: decimation, filter mode, settle code, repeats
	localparam int unsigned SU_DEC_LSB = 0;
	localparam int unsigned SU_MODE_LSB = 11;
	localparam int unsigned SU_SET_LSB = 15;
	localparam int unsigned SU_REP_LSB = 18;
	localparam logic [21:0] SETUP_RESET = 22'h000001;

	// Filter modes
	localparam logic [3:0] FM_SINC4 = 4'h0;
	localparam logic [3:0] FM_SINC4_AVG = 4'h1;
	localparam logic [3:0] FM_SINC3 = 4'h2;
	localparam logic [3:0] FM_SINC3_NOTCH = 4'h3;
	localparam logic [3:0] FM_SINC3_AVG = 4'h4;
	localparam logic [3:0] FM_POST1 = 4'h5;
	localparam logic [3:0] FM_POST2 = 4'h6;
	localparam logic [3:0] FM_POST3 = 4'h7;
	localparam logic [3:0] FM_POST4 = 4'h8;

	// Conversion timing figures in main clock cycles
	localparam int unsigned AVG = 8;
	localparam logic [TW-1:0] AVG4_MUL = TW'((4 + AVG - 1) * 32);
	localparam logic [TW-1:0] AVG3_MUL = TW'((3 + AVG - 1) * 32);
	localparam logic [TW-1:0] POST1_CYC = 28'h0000b80;
	localparam logic [TW-1:0] POST2_CYC = 28'h0000c80;
	localparam logic [TW-1:0] POST3_CYC = 28'h0000f80;
	localparam logic [TW-1:0] POST4_CYC = 28'h0001280;
	localparam logic [TW-1:0] DPP_SHORT = 28'h000001c;
	localparam logic [TW-1:0] DPP_LONG = 28'h000003e;
	localparam logic [TW-1:0] DPP_POST = 28'h0000045;
	localparam logic [TW-1:0] SETTLE_BASE = 28'h0000020;
	localparam logic [TW-1:0] RATIO_QUARTER = 28'h0000003;
	localparam logic [TW-1:0] RATIO_SIXTEENTH = 28'h000000f;

	// Wake times in main clock cycles; plain defaults
	localparam logic [TW-1:0] DUTY_WAKE_CYC = 28'h0000010;
	localparam logic [TW-1:0] OSC_WAKE_CYC = 28'h0000040;

	typedef enum logic [2:0] {
		ST_IDLE, ST_SETTLE, ST_CONV, ST_STBY, ST_WAKE
	} ast_state_type;
endpackage : ast_pkg

// [ast_seq_timing_checker.sv]
`timescale 1ns/1ps
module ast_seq_timing_checker (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic data_ready_n, // Result ready, low
	input wire logic [2:0] result_channel, // Result channel
	input wire logic conv_active, // Acquisition running
	input wire logic [3:0] filter_mode_out, // Filter mode
	input wire logic [10:0] decimation_out, // Decimation
	input wire logic standby_indicator_output, // Low in standby
	input wire logic osc_enable // Oscillator enable
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	// Bus and result steps
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_low8;
		##1 (!data_ready_n) [*8];
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_one_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_drdy_holds: assert property ($fell(data_ready_n) |-> s_low8)
		else $error("data ready low too briefly");
	a_result_ch_held: assert property (!data_ready_n && !$past(data_ready_n)
		|-> $stable(result_channel))
		else $error("result channel moved while ready low");
	a_no_conv_stby: assert property (!standby_indicator_output
		|-> !conv_active)
		else $error("conversion during standby");
	a_no_conv_osc: assert property (!osc_enable |-> !conv_active)
		else $error("conversion with oscillator off");
	a_setup_held: assert property (conv_active && $past(conv_active)
		|-> $stable(decimation_out) && $stable(filter_mode_out))
		else $error("filter setup changed mid conversion");
	a_conv_min_len: assert property ($rose(conv_active)
		|-> conv_active [*8])
		else $error("conversion shorter than a tick");
endmodule : ast_seq_timing_checker

// [ast_host_model.sv]
`timescale 1ns/1ps
module ast_host_model (
	input wire logic pclk, // Clock
	output logic psel, // APB select
	output logic penable, // APB enable
	output logic pwrite, // APB direction
	output logic [7:0] paddr, // APB address
	output logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr // APB error
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// One transfer; waits on pready, never assumes a latency
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Inverted leftovers so stale lines never look valid
		paddr <= ~a;
		pwdata <= ~wd;
	endtask : xfer
endmodule : ast_host_model

// [tb_adc_sequencer_timing.sv]
`timescale 1ns/1ps
module tb_adc_sequencer_timing;
	import ast_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic data_ready_n, conv_active, standby_indicator_output, osc_enable;
	logic [2:0] result_channel;
	logic [3:0] filter_mode_out;
	logic [10:0] decimation_out;
	int n_mismatch, n_tests;

	ast_seq_timing u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .data_ready_n, .result_channel,
		.conv_active, .active_channel(), .filter_mode_out, .decimation_out,
		.standby_indicator_output, .osc_enable);
	ast_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);

	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rd, err);
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [31:0] e);
		u_host.xfer(1'b0, a, 32'h0, rd, err);
		check(rd, e);
	endtask : rdchk

	// Ideal first conversion time in main clock ticks
	function automatic logic [31:0] ideal(input logic [3:0] m,
		input logic [10:0] d);
		case (m)
			FM_SINC4: return 32'(d) * 128;
			FM_SINC4_AVG: return 32'(d) * 352;
			FM_SINC3_AVG: return 32'(d) * 320;
			FM_POST1: return 32'h0b80;
			FM_POST2: return 32'h0c80;
			FM_POST3: return 32'h0f80;
			FM_POST4: return 32'h1280;
			default: return 32'(d) * 96;
		endcase
	endfunction : ideal

	task conclude;
		$display("mismatches=%0d checks=%0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		check(32'(data_ready_n), 32'h1);
		check(32'(standby_indicator_output), 32'h1);
		check(32'(osc_enable), 32'h1);
		rdchk(OFS_CTRL, 32'h0);
		rdchk(OFS_CHAN_EN, 32'h1);
		rdchk(OFS_SETUP0, 32'h1);
		wr(OFS_ACTIVE, 32'hffff);
		rdchk(OFS_ACTIVE, 32'ha0);
		wr(8'h44, 32'hffff);
		check(32'(err), 32'h1);
		rdchk(8'h44, 32'h0);
	endtask : t_reset

	// Every filter mode and settle code through the derived intervals
	task t_intervals;
		logic [31:0] e;
		for (int i = 0; i < 9; i++) begin
			e = ideal(4'(i), 11'h005);
			wr(OFS_SETUP0, 32'h5 | (32'(i) << 11) | (32'(i % 8) << 15));
			wr(OFS_CTRL, 32'h0);
			rdchk(OFS_ACTIVE, (32'h20 << (i % 8)) + e);
			rdchk(OFS_STANDBY, 3 * e - 32'h10);
			wr(OFS_CTRL, 32'h4);
			rdchk(OFS_STANDBY, 15 * e - 32'h10);
		end
		// Widest decimation, longest settle on a second channel
		wr(OFS_SETUP0 + 8'h04, 32'h7ff | (32'h7 << 15));
		wr(OFS_CHAN_EN, 32'h3);
		rdchk(OFS_ACTIVE, 32'h20 + 32'h1280 + 32'h1000 + 32'h7ff * 128);
	endtask : t_intervals

	// Shared setup, no repeats: fixed spacing, alternating channels
	task t_sequence;
		int n;
		logic [31:0] cfg;
		cfg = 32'(FM_SINC3) << 11;
		wr(OFS_SETUP0, cfg);
		wr(OFS_SETUP0 + 8'h04, cfg);
		wr(OFS_CHAN_EN, 32'h3);
		wr(OFS_CTRL, 32'h1);
		for (int k = 0; k < 3; k++) begin
			n = 0;
			while (data_ready_n !== 1'b1 && n < 40000) begin
				@(posedge pclk);
				n++;
			end
			while (data_ready_n !== 1'b0 && n < 40000) begin
				@(posedge pclk);
				n++;
			end
			if (k == 0) begin
				check(32'(n >= 60 * 260 && n <= 62 * 260 + 20), 32'h1);
			end else begin
				check(32'((n + 130) / 260), 32'd33);
			end
			check(32'(result_channel), 32'(k % 2));
		end
		wr(OFS_CTRL, 32'h0);
		repeat (4) @(posedge pclk);
		check(32'(data_ready_n), 32'h1);
	endtask : t_sequence

	// Host standby: oscillator off, wake before settling
	task t_standby;
		int n;
		wr(OFS_CHAN_EN, 32'h1);
		wr(OFS_CTRL, 32'h9);
		repeat (4) @(posedge pclk);
		check(32'(standby_indicator_output), 32'h0);
		check(32'(osc_enable), 32'h0);
		wr(OFS_CTRL, 32'h1);
		n = 0;
		while (conv_active !== 1'b1 && n < 40000) begin
			@(posedge pclk);
			n++;
		end
		check(32'(n >= 95 * 260 && n <= 97 * 260 + 20), 32'h1);
		check(32'(osc_enable), 32'h1);
		wr(OFS_CTRL, 32'h0);
	endtask : t_standby

	////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Main sequence
	initial begin
		presetn = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_intervals;
		t_sequence;
		t_standby;
		conclude;
	end

	// Watchdog, about half again the expected run
	initial begin
		repeat (90000) @(posedge pclk);
		n_mismatch++;
		conclude;
	end
endmodule : tb_adc_sequencer_timing

bind ast_seq_timing ast_seq_timing_checker u_chk (.pclk, .presetn, .psel,
	.penable, .prdata, .pready, .pslverr, .data_ready_n, .result_channel,
	.conv_active, .filter_mode_out, .decimation_out,
	.standby_indicator_output, .osc_enable);
